//--- src/usb_ps2_regs_pkg.sv
// Package with register offsets, field positions and reset values of the USB/PS2 register bank.
// Assumes byte addressing on a 32-bit APB bus, one register per aligned word.
package usb_ps2_regs_pkg;
    localparam int ADDR_W = 8;
    // Printed offsets are register indexes; byte address is four times the index.
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h14;
    localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h15;
    localparam logic [7:0] IDX_BUS_STATUS_CONTROL = 8'h1A;
    localparam logic [7:0] IDX_ENDPOINT_FLAGS = 8'h1B;
    localparam logic [7:0] IDX_SYSTEM_CLOCK_CONTROL = 8'h1C;
    localparam logic [7:0] IDX_TABLE_HIGH_POINTER = 8'h1F;
    localparam logic [7:0] IDX_WAKE_OPTION = 8'h20;
    // Status-control fields.
    localparam int BSC_SUSPEND = 0;
    localparam int BSC_REMOTE_WAKE = 1;
    localparam int BSC_BUS_RESET = 2;
    localparam int BSC_RESUME = 3;
    localparam int BSC_DATA_IN = 4;
    localparam int BSC_CLOCK_IN = 5;
    localparam int BSC_DATA_OUT = 6;
    localparam int BSC_CLOCK_OUT = 7;
    // Endpoint flags and bus select fields.
    localparam int EPF_EP0 = 0;
    localparam int EPF_EP2 = 2;
    localparam int EPF_PS2_SEL = 4;
    localparam int EPF_USB_SEL = 5;
    localparam int EPF_USB_MARKER = 7;
    localparam logic [7:0] EPF_WRITE_MASK = 8'hB7;
    // Clock control fields.
    localparam int SCC_USB_CLOCK = 3;
    localparam int SCC_DEEP_SUSPEND = 4;
    localparam int SCC_OSC_SELECT = 6;
    localparam int SCC_PS2_MARKER = 7;
    localparam logic [7:0] SCC_WRITE_MASK = 8'hD8;
    // Wake-capable port B bits.
    localparam int PB_WAKE_A = 4;
    localparam int PB_WAKE_B = 7;
    // Reset values.
    localparam logic [7:0] PORT_B_DATA_RESET = 8'hFF;
    localparam logic [7:0] PORT_B_DIRECTION_RESET = 8'hFF;
    localparam logic [1:0] PS2_OUT_RESET = 2'h3;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

//--- src/usb_ps2_status_control_regs.sv
// Register bank for USB/PS2 status, endpoint flags, clock control, port B and table high pointer.
// Assumes an APB master on pclk; USB engine events are one-cycle pulses synchronous to pclk.
//
// Notes on behaviour
// - Suspend bit reads live suspend status.
// - Writing remote wake drives wake pulse.
// - Bus reset flag, hardware set, RW.
// - Resume flag set by resume event.
// - Data out bit drives PS/2 data.
// - Host endpoint access sets flag, interrupt if enabled, flag clear and stack not full.
// - Endpoint flags bits 0..2, reset zero.
// - Bit 4 selects PS/2 operation.
// - Bit 5 selects USB operation.
// - USB marker bit, firmware read/write.
// - Clock control bit 3 gates USB clock.
// - Deep suspend not settable in USB mode.
// - Bit 6 selects 6 or 12 MHz.
// - PS/2 marker bit, firmware read/write.
// - Pointer holds table word bits 11..8.
// - Table pointer is build option, off.
// - Port B data RW; bits 4,7 wake.
// - Direction register sets each port B bit.
// - Bits 4,5 return PS/2 line levels.
// - Bit 7 drives PS/2 clock line.
// - Line reads zero unless output bit one.
// - Select bits route pins to PS/2 or USB.
`timescale 1ns/1ps
module usb_ps2_status_control_regs
    import usb_ps2_regs_pkg::*;
#(
    parameter bit TABLE_POINTER_ENABLE = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic usb_suspend,
    input wire logic usb_bus_reset_event,
    input wire logic usb_resume_event,
    input wire logic [2:0] endpoint_access,
    input wire logic usb_int_enable,
    input wire logic stack_full,
    input wire logic table_read_strobe,
    input wire logic [14:0] table_read_word,
    input wire logic [7:0] port_b_in,
    input wire logic minus_pin_in,
    input wire logic plus_pin_in,
    input wire logic usb_minus_out,
    input wire logic usb_minus_oe,
    input wire logic usb_plus_out,
    input wire logic usb_plus_oe,
    output logic minus_pin_out,
    output logic minus_pin_oe,
    output logic plus_pin_out,
    output logic plus_pin_oe,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic remote_wakeup_pulse,
    output logic usb_interrupt,
    output logic usb_clock_gate,
    output logic deep_suspend_ctrl,
    output logic oscillator_freq_select,
    output logic ps2_bus_select,
    output logic usb_bus_select,
    output logic wake_request
);
    logic [7:0] port_b_data_r;
    logic [7:0] port_b_direction_r;
    logic bus_reset_seen_r;
    logic resume_seen_r;
    logic ps2_data_out_r;
    logic ps2_clock_out_r;
    logic [2:0] endpoint_request_r;
    logic ps2_sel_r;
    logic usb_sel_r;
    logic usb_marker_r;
    logic usb_clock_r;
    logic deep_suspend_r;
    logic osc_sel_r;
    logic ps2_marker_r;
    logic [3:0] table_high_r;
    logic [1:0] wake_enable_r;
    logic [1:0] wake_prev_r;
    logic [7:0] rd_byte;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] index;
    logic [7:0] wbyte;
    logic ps2_mode;
    logic ps2_data_in;
    logic ps2_clock_in;
    logic [1:0] wake_pins;

    assign index = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0) &&
        (index == IDX_PORT_B_DATA || index == IDX_PORT_B_DIRECTION || index == IDX_BUS_STATUS_CONTROL ||
         index == IDX_ENDPOINT_FLAGS || index == IDX_SYSTEM_CLOCK_CONTROL ||
         index == IDX_TABLE_HIGH_POINTER || index == IDX_WAKE_OPTION);
    assign wr_en = psel && penable && pready && pwrite && addr_ok && pstrb[0];
    assign rd_en = psel && !penable && !pwrite;
    assign ps2_mode = ps2_sel_r && !usb_sel_r;
    assign ps2_data_in = minus_pin_in && ps2_data_out_r;
    assign ps2_clock_in = plus_pin_in && ps2_clock_out_r;
    assign wake_pins = {port_b_in[PB_WAKE_B], port_b_in[PB_WAKE_A]};

    always_comb begin
        rd_byte = ZERO_BYTE;
        case (index)
            IDX_PORT_B_DATA: begin
                rd_byte = port_b_data_r;
            end
            IDX_PORT_B_DIRECTION: begin
                rd_byte = port_b_direction_r;
            end
            // Status and line levels; write-only bits read zero.
            IDX_BUS_STATUS_CONTROL: begin
                rd_byte = {2'h0, ps2_clock_in, ps2_data_in, resume_seen_r, bus_reset_seen_r, 1'b0, usb_suspend};
            end
            IDX_ENDPOINT_FLAGS: begin
                rd_byte = {usb_marker_r, 1'b0, usb_sel_r, ps2_sel_r, 1'b0, endpoint_request_r};
            end
            IDX_SYSTEM_CLOCK_CONTROL: begin
                rd_byte = {ps2_marker_r, osc_sel_r, 1'b0, deep_suspend_r, usb_clock_r, 3'h0};
            end
            IDX_TABLE_HIGH_POINTER: begin
                rd_byte = {4'h0, table_high_r};
            end
            IDX_WAKE_OPTION: begin
                rd_byte = {6'h0, wake_enable_r};
            end
            default: begin
                rd_byte = ZERO_BYTE;
            end
        endcase
    end

    // Two-cycle APB: one setup and one access cycle; bad address answers with an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en) begin
                prdata <= addr_ok ? {24'h0, rd_byte} : 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_data_r <= PORT_B_DATA_RESET;
        end else if (wr_en && index == IDX_PORT_B_DATA) begin
            port_b_data_r <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_direction_r <= PORT_B_DIRECTION_RESET;
        end else if (wr_en && index == IDX_PORT_B_DIRECTION) begin
            port_b_direction_r <= wbyte;
        end
    end

    // Wake enable bits for the two wake-capable pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_enable_r <= 2'h0;
        end else if (wr_en && index == IDX_WAKE_OPTION) begin
            wake_enable_r <= wbyte[1:0];
        end
    end

    // Bus reset flag; event wins over write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_reset_seen_r <= 1'b0;
        end else if (usb_bus_reset_event) begin
            bus_reset_seen_r <= 1'b1;
        end else if (wr_en && index == IDX_BUS_STATUS_CONTROL) begin
            bus_reset_seen_r <= wbyte[BSC_BUS_RESET];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume_seen_r <= 1'b0;
        end else if (usb_resume_event) begin
            resume_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps2_data_out_r <= PS2_OUT_RESET[0];
            ps2_clock_out_r <= PS2_OUT_RESET[1];
        end else begin
            if (wr_en && index == IDX_BUS_STATUS_CONTROL) begin
                ps2_data_out_r <= wbyte[BSC_DATA_OUT];
                ps2_clock_out_r <= wbyte[BSC_CLOCK_OUT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_wakeup_pulse <= 1'b0;
        end else begin
            remote_wakeup_pulse <= wr_en && index == IDX_BUS_STATUS_CONTROL && wbyte[BSC_REMOTE_WAKE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            endpoint_request_r <= 3'h0;
        end else begin
            if (wr_en && index == IDX_ENDPOINT_FLAGS) begin
                endpoint_request_r <= wbyte[EPF_EP2:EPF_EP0] & EPF_WRITE_MASK[2:0];
            end
            // Access sets flag; set wins over clear.
            for (int i = 0; i < 3; i++) begin
                if (endpoint_access[i]) begin
                    endpoint_request_r[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps2_sel_r <= 1'b0;
            usb_sel_r <= 1'b0;
            usb_marker_r <= 1'b0;
        end else if (wr_en && index == IDX_ENDPOINT_FLAGS) begin
            ps2_sel_r <= wbyte[EPF_PS2_SEL];
            usb_sel_r <= wbyte[EPF_USB_SEL];
            usb_marker_r <= wbyte[EPF_USB_MARKER];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_interrupt <= 1'b0;
        end else begin
            usb_interrupt <= (|(endpoint_access & ~endpoint_request_r)) && usb_int_enable && !stack_full;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_clock_r <= 1'b0;
            deep_suspend_r <= 1'b0;
            osc_sel_r <= 1'b0;
            ps2_marker_r <= 1'b0;
        end else if (wr_en && index == IDX_SYSTEM_CLOCK_CONTROL) begin
            usb_clock_r <= wbyte[SCC_USB_CLOCK];
            // Deep suspend blocked in USB mode.
            deep_suspend_r <= wbyte[SCC_DEEP_SUSPEND] && !usb_sel_r;
            osc_sel_r <= wbyte[SCC_OSC_SELECT];
            ps2_marker_r <= wbyte[SCC_PS2_MARKER];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_high_r <= 4'h0;
        end else if (TABLE_POINTER_ENABLE) begin
            if (table_read_strobe) begin
                table_high_r <= table_read_word[11:8];
            end else if (wr_en && index == IDX_TABLE_HIGH_POINTER) begin
                table_high_r <= wbyte[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_prev_r <= 2'h3;
            wake_request <= 1'b0;
        end else begin
            wake_prev_r <= wake_pins;
            wake_request <= |(wake_prev_r & ~wake_pins & wake_enable_r);
        end
    end

    // Registered pin and control outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            minus_pin_out <= 1'b0;
            minus_pin_oe <= 1'b0;
            plus_pin_out <= 1'b0;
            plus_pin_oe <= 1'b0;
        end else begin
            // Open-drain PS/2 or USB engine drive.
            if (ps2_mode) begin
                minus_pin_out <= 1'b0;
                minus_pin_oe <= !ps2_data_out_r;
                plus_pin_out <= 1'b0;
                plus_pin_oe <= !ps2_clock_out_r;
            end else if (usb_sel_r && !ps2_sel_r) begin
                minus_pin_out <= usb_minus_out;
                minus_pin_oe <= usb_minus_oe;
                plus_pin_out <= usb_plus_out;
                plus_pin_oe <= usb_plus_oe;
            end else begin
                minus_pin_out <= 1'b0;
                minus_pin_oe <= 1'b0;
                plus_pin_out <= 1'b0;
                plus_pin_oe <= 1'b0;
            end
        end
    end

    // Registered port B, clock control and bus select outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_out <= ZERO_BYTE;
            port_b_oe <= ZERO_BYTE;
            usb_clock_gate <= 1'b0;
            deep_suspend_ctrl <= 1'b0;
            oscillator_freq_select <= 1'b0;
            ps2_bus_select <= 1'b0;
            usb_bus_select <= 1'b0;
        end else begin
            // Direction: 1 is input, 0 drives.
            port_b_out <= port_b_data_r;
            port_b_oe <= ~port_b_direction_r;
            usb_clock_gate <= usb_clock_r;
            deep_suspend_ctrl <= deep_suspend_r;
            oscillator_freq_select <= osc_sel_r;
            ps2_bus_select <= ps2_sel_r;
            usb_bus_select <= usb_sel_r;
        end
    end
endmodule // usb_ps2_status_control_regs

//--- verification/usb_ps2_status_control_regs_checker.sv
// Checker for the USB/PS2 register bank, watching its ports.
// Assumes APB accesses and registered outputs one cycle after the registers.
`timescale 1ns/1ps
module usb_ps2_status_control_regs_checker
    import usb_ps2_regs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [2:0] endpoint_access,
    input wire logic usb_int_enable,
    input wire logic stack_full,
    input wire logic usb_minus_out,
    input wire logic usb_minus_oe,
    input wire logic minus_pin_out,
    input wire logic minus_pin_oe,
    input wire logic plus_pin_out,
    input wire logic remote_wakeup_pulse,
    input wire logic usb_interrupt,
    input wire logic usb_clock_gate,
    input wire logic deep_suspend_ctrl,
    input wire logic oscillator_freq_select,
    input wire logic ps2_bus_select,
    input wire logic usb_bus_select
);
    logic wr_ok;
    logic [7:0] wr_idx;
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && paddr[31:10] == 22'h0 && paddr[1:0] == 2'b00;
    assign wr_idx = paddr[9:2];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_wake_pulse: assert property (wr_ok && wr_idx == IDX_BUS_STATUS_CONTROL && pwdata[1] |=> remote_wakeup_pulse)
        else $error("remote wake-up pulse missing");
    chk_irq_cause: assert property (usb_interrupt |-> $past(endpoint_access) != 3'h0 && $past(usb_int_enable) && !$past(stack_full))
        else $error("interrupt without enabled endpoint access");
    chk_usb_clock: assert property (wr_ok && wr_idx == IDX_SYSTEM_CLOCK_CONTROL |-> ##2 usb_clock_gate == $past(pwdata[3], 2))
        else $error("usb clock gate does not follow bit 3");
    chk_deep_block: assert property (wr_ok && wr_idx == IDX_SYSTEM_CLOCK_CONTROL && usb_bus_select |-> ##2 !deep_suspend_ctrl)
        else $error("deep suspend set in usb mode");
    chk_osc_select: assert property (wr_ok && wr_idx == IDX_SYSTEM_CLOCK_CONTROL |-> ##2 oscillator_freq_select == $past(pwdata[6], 2))
        else $error("oscillator select does not follow bit 6");
    chk_ps2_select: assert property (wr_ok && wr_idx == IDX_ENDPOINT_FLAGS |-> ##2 ps2_bus_select == $past(pwdata[4], 2))
        else $error("ps2 select does not follow bit 4");
    chk_usb_select: assert property (wr_ok && wr_idx == IDX_ENDPOINT_FLAGS |-> ##2 usb_bus_select == $past(pwdata[5], 2))
        else $error("usb select does not follow bit 5");
    chk_usb_pins: assert property (usb_bus_select && !ps2_bus_select && $past(usb_bus_select) && !$past(ps2_bus_select)
        |-> minus_pin_out == $past(usb_minus_out) && minus_pin_oe == $past(usb_minus_oe))
        else $error("usb engine does not drive minus pin");
    chk_ps2_low: assert property (ps2_bus_select && !usb_bus_select && $past(ps2_bus_select) && !$past(usb_bus_select)
        |-> !minus_pin_out && !plus_pin_out)
        else $error("ps2 pins driven high");
endmodule // usb_ps2_status_control_regs_checker

bind usb_ps2_status_control_regs usb_ps2_status_control_regs_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .endpoint_access, .usb_int_enable, .stack_full, .usb_minus_out, .usb_minus_oe,
    .minus_pin_out, .minus_pin_oe, .plus_pin_out, .remote_wakeup_pulse, .usb_interrupt, .usb_clock_gate,
    .deep_suspend_ctrl, .oscillator_freq_select, .ps2_bus_select, .usb_bus_select);

//--- verification/ps2_host_model.sv
// Host side of the shared pins: open-drain lines with pull-ups.
// Assumes the device pulls a line only while its enable is high.
`timescale 1ns/1ps
module ps2_host_model (
    input wire logic minus_pin_out,
    input wire logic minus_pin_oe,
    input wire logic plus_pin_out,
    input wire logic plus_pin_oe,
    input wire logic host_data_low,
    input wire logic host_clock_low,
    output logic minus_pin_in,
    output logic plus_pin_in
);
    assign minus_pin_in = !(minus_pin_oe && !minus_pin_out) && !host_data_low;
    assign plus_pin_in = !(plus_pin_oe && !plus_pin_out) && !host_clock_low;
endmodule // ps2_host_model

//--- verification/usb_ps2_status_control_regs_tb.sv
// Testbench for the USB/PS2 register bank over APB.
// Assumes the package constants and the host model on the shared pins.
`timescale 1ns/1ps
module usb_ps2_status_control_regs_tb;
    import usb_ps2_regs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, usb_suspend, usb_bus_reset_event;
    logic usb_resume_event, usb_int_enable, stack_full, table_read_strobe, minus_pin_in, plus_pin_in;
    logic usb_minus_out, usb_minus_oe, usb_plus_out, usb_plus_oe, minus_pin_out, minus_pin_oe, plus_pin_out;
    logic plus_pin_oe, remote_wakeup_pulse, usb_interrupt, usb_clock_gate, deep_suspend_ctrl;
    logic oscillator_freq_select, ps2_bus_select, usb_bus_select, wake_request, host_data_low, host_clock_low;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] endpoint_access;
    logic [14:0] table_read_word;
    logic [7:0] port_b_in, port_b_out, port_b_oe, q;
    int errors, n_tests, n_irq, n_rw, n_wake;
    localparam logic [7:0] st = IDX_BUS_STATUS_CONTROL;
    localparam logic [7:0] ep = IDX_ENDPOINT_FLAGS;
    localparam logic [7:0] cc = IDX_SYSTEM_CLOCK_CONTROL;
    logic [7:0] ri[6] = '{IDX_PORT_B_DATA, IDX_PORT_B_DIRECTION, st, ep, cc, IDX_TABLE_HIGH_POINTER};
    logic [7:0] rv[6] = '{8'hFF, 8'hFF, 8'h30, 8'h00, 8'h00, 8'h00};
    usb_ps2_status_control_regs #(.TABLE_POINTER_ENABLE(1'b1)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .usb_suspend, .usb_bus_reset_event, .usb_resume_event,
        .endpoint_access, .usb_int_enable, .stack_full, .table_read_strobe, .table_read_word, .port_b_in,
        .minus_pin_in, .plus_pin_in, .usb_minus_out, .usb_minus_oe, .usb_plus_out, .usb_plus_oe, .minus_pin_out,
        .minus_pin_oe, .plus_pin_out, .plus_pin_oe, .port_b_out, .port_b_oe, .remote_wakeup_pulse, .usb_interrupt,
        .usb_clock_gate, .deep_suspend_ctrl, .oscillator_freq_select, .ps2_bus_select, .usb_bus_select, .wake_request);
    ps2_host_model i_host (.minus_pin_out, .minus_pin_oe, .plus_pin_out, .plus_pin_oe, .host_data_low,
        .host_clock_low, .minus_pin_in, .plus_pin_in);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        n_irq <= n_irq + (usb_interrupt === 1'b1);
        n_rw <= n_rw + (remote_wakeup_pulse === 1'b1);
        n_wake <= n_wake + (wake_request === 1'b1);
    end
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
        if (k == 20) begin
            errors++;
            test_done();
        end
        q = prdata[7:0];
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [7:0] i, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(nm, q & m, e);
    endtask
    task automatic ep_hit(input logic [2:0] m);
        @(posedge pclk);
        endpoint_access <= m;
        @(posedge pclk);
        endpoint_access <= 3'h0;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, usb_suspend, usb_bus_reset_event, usb_resume_event, usb_int_enable} = 8'h00;
        {stack_full, table_read_strobe, usb_minus_out, usb_minus_oe, usb_plus_out, usb_plus_oe} = 6'h00;
        {host_data_low, host_clock_low, endpoint_access, paddr, pwdata} = 69'h0;
        {errors, n_tests, n_irq, n_rw, n_wake} = '0;
        pstrb = 4'hF;
        table_read_word = 15'h0000;
        port_b_in = 8'hFF;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int j = 0; j < 6; j++) rc("reset", ri[j], 8'hFF, rv[j]);
        apb(1'b1, ri[0], 8'h5A);
        rc("port_b", ri[0], 8'hFF, 8'h5A);
        chk("port_b_out", port_b_out, 8'h5A);
        apb(1'b1, ri[1], 8'h0F);
        rc("direction", ri[1], 8'hFF, 8'h0F);
        chk("port_b_oe", port_b_oe, 8'hF0);
        apb(1'b0, 8'h30, 8'h00);
        chk("unmapped", {q[6:0], slv}, 8'h01);
        usb_suspend <= 1'b1;
        usb_bus_reset_event <= 1'b1;
        usb_resume_event <= 1'b1;
        @(posedge pclk);
        usb_bus_reset_event <= 1'b0;
        usb_resume_event <= 1'b0;
        rc("status", st, 8'h0F, 8'h0D);
        apb(1'b1, st, 8'hC2);
        rc("status", st, 8'h0F, 8'h09);
        chk("wake_pulses", n_rw[7:0], 8'h01);
        apb(1'b1, ep, 8'h10);
        apb(1'b1, st, 8'h80);
        rc("ps2_lines", st, 8'h30, 8'h20);
        host_clock_low <= 1'b1;
        rc("ps2_clock", st, 8'h30, 8'h00);
        host_clock_low <= 1'b0;
        apb(1'b1, st, 8'hC0);
        rc("ps2_release", st, 8'h30, 8'h30);
        {usb_minus_out, usb_minus_oe, usb_plus_out, usb_plus_oe} <= 4'hB;
        usb_int_enable <= 1'b1;
        apb(1'b1, ep, 8'h20);
        rc("usb_mode", ep, 8'hF0, 8'h20);
        chk("usb_pins", {4'h0, minus_pin_oe, minus_pin_out, plus_pin_oe, plus_pin_out}, 8'h07);
        ep_hit(3'b010);
        rc("ep_flags", ep, 8'h07, 8'h02);
        ep_hit(3'b010);
        stack_full <= 1'b1;
        ep_hit(3'b100);
        rc("ep_flags", ep, 8'h07, 8'h06);
        chk("irq_count", n_irq[7:0], 8'h01);
        stack_full <= 1'b0;
        apb(1'b1, ep, 8'hA0);
        rc("ep_clear", ep, 8'hFF, 8'hA0);
        apb(1'b1, cc, 8'hD8);
        rc("clock_usb", cc, 8'hFF, 8'hC8);
        chk("clock_outs", {5'h0, usb_clock_gate, deep_suspend_ctrl, oscillator_freq_select}, 8'h05);
        apb(1'b1, ep, 8'h10);
        apb(1'b1, cc, 8'h10);
        rc("clock_ps2", cc, 8'hFF, 8'h10);
        chk("deep_out", {7'h0, deep_suspend_ctrl}, 8'h01);
        table_read_word <= 15'h0A5C;
        table_read_strobe <= 1'b1;
        @(posedge pclk);
        table_read_strobe <= 1'b0;
        rc("table_high", ri[5], 8'h0F, 8'h0A);
        apb(1'b1, IDX_WAKE_OPTION, 8'h01);
        port_b_in <= 8'hEF;
        repeat (4) @(posedge pclk);
        port_b_in <= 8'h6F;
        repeat (4) @(posedge pclk);
        chk("wake_count", n_wake[7:0], 8'h01);
        test_done();
    end
endmodule // usb_ps2_status_control_regs_tb
